/* rtl/shift_rotate_pkg.sv */
// shared constants for the shift / rotate / flag-load unit
// assumes the front end hands over a decoded opcode byte, modrm reg field and size
package shift_rotate_pkg;

  localparam logic [7:0] OPC_GRP2_BYTE_ONE = 8'hD0;
  localparam logic [7:0] OPC_GRP2_WORD_ONE = 8'hD1;
  localparam logic [7:0] OPC_GRP2_BYTE_CNT = 8'hD2;
  localparam logic [7:0] OPC_GRP2_WORD_CNT = 8'hD3;
  localparam logic [7:0] OPC_GRP2_BYTE_IMM = 8'hC0;
  localparam logic [7:0] OPC_GRP2_WORD_IMM = 8'hC1;
  localparam logic [7:0] OPC_FLAG_LOAD = 8'h9E;

  localparam logic [2:0] EXT_ROTATE_LEFT = 3'h0;
  localparam logic [2:0] EXT_ROTATE_RIGHT = 3'h1;
  localparam logic [2:0] EXT_SHIFT_LEFT = 3'h4;

  // operand size codes from the front end
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  localparam logic [1:0] SIZE_64 = 2'h3;

  // flag positions in the low flag byte: sign, zero, aux carry, parity, carry
  localparam logic [7:0] FLAG_LOAD_MASK = 8'hD5;
  localparam logic [7:0] FLAG_FIXED_ONE = 8'h02;
  localparam logic [63:0] FLAGS_RESET = 64'h0000000000000002;

  typedef enum logic [1:0] {
    op_none,
    op_rotate_left,
    op_rotate_right,
    op_shift_left
  } shift_kind_t;

  typedef enum logic [1:0] {
    src_one,
    src_count,
    src_imm
  } count_src_t;

endpackage

/* rtl/shift_core.sv */
// combinational shift / rotate of one operand at a chosen width
// assumes the caller merges the bits above the width, registers the result and passes a masked count
`timescale 1ns/100ps
`default_nettype none
module shift_core
  import shift_rotate_pkg::*;
#(
  parameter int DATA_W = 64
) (
  input wire logic [DATA_W-1:0] operand,
  input wire logic [1:0] size,
  input wire logic [5:0] amount,
  input wire shift_kind_t kind,
  output logic [DATA_W-1:0] result
);

  if (DATA_W != 64) begin : g_width_check
    $error("shift_core serves 64-bit data only");
  end

  logic [127:0] dbl;
  logic [63:0] val;
  logic [6:0] width;
  logic [6:0] amt;

  always_comb begin
    val = 64'h0;
    width = 7'd64;
    case (size)
      SIZE_8: begin
        val = {56'h0, operand[7:0]};
        width = 7'd8;
      end
      SIZE_16: begin
        val = {48'h0, operand[15:0]};
        width = 7'd16;
      end
      SIZE_32: begin
        val = {32'h0, operand[31:0]};
        width = 7'd32;
      end
      default: begin
        val = operand;
        width = 7'd64;
      end
    endcase
    // rotate counts beyond the width wrap around the width
    amt = {1'b0, amount} % width;
    dbl = 128'h0;
    result = operand;
    case (kind)
      op_rotate_left: begin
        dbl = ({64'h0, val} << amt) | ({64'h0, val} >> (width - amt));
        result = dbl[63:0];
      end
      op_rotate_right: begin
        dbl = ({64'h0, val} >> amt) | ({64'h0, val} << (width - amt));
        result = dbl[63:0];
      end
      op_shift_left: begin
        dbl = {64'h0, val} << amount;
        result = dbl[63:0];
      end
      default: result = operand;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/shift_rotate_flag_load_unit.sv */
// decode and execute of rotate, left shift and flag-byte load instructions
// assumes one instruction per valid pulse; operands already fetched by the front end
// the result port is a write-back image; memory addressing and shift flags live elsewhere
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// RULE1 - opcode D3 with extension 0 rotates the operand left by the count register low byte.
// RULE2 - opcode C1 with extension 0 rotates the 32 or 64 bit operand left by the immediate byte.
// RULE3 - the one-bit right rotate wraps the low bit into the top for 8 and 64 bit operands.
// RULE4 - a 32-bit right rotate can take its amount from the count register low byte.
// RULE5 - a 64-bit right rotate can take its amount from the trailing immediate byte.
// RULE6 - the flag-load opcode copies sign, zero, aux carry, parity and carry from the accumulator high byte.
// RULE7 - byte opcodes D0, D2 and C0 with extension 4 shift left by one, count register or immediate.
// RULE8 - word opcodes D1, D3 and C1 with extension 4 shift a 16-bit operand left the same three ways.
// RULE9 - the word opcodes with extension 4 also serve 32 and 64 bit operands, sized by operand-size state.
// RULE10 - the logical left shift shares the arithmetic left shift encodings and gives the same result.
// RULE11 - right rotate is decoded with extension field 1 to avoid clashing with left rotate.
module shift_rotate_flag_load_unit
  import shift_rotate_pkg::*;
#(
  parameter int DATA_W = 64
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [2:0] modrm_ext,
  input wire logic [1:0] operand_size,
  input wire logic [DATA_W-1:0] operand,
  input wire logic [7:0] imm8,
  input wire logic [7:0] count_reg_low_byte,
  input wire logic [7:0] accumulator_high_byte,
  output logic result_valid,
  output logic [DATA_W-1:0] result,
  output logic [1:0] result_size,
  output logic illegal,
  output logic flags_valid,
  output logic [DATA_W-1:0] flags_register
);

  // only the 64-bit datapath is built; narrower parts would need their own merge
  if (DATA_W != 64) begin : g_width_check
    $error("unit serves 64-bit operands only");
  end

  ////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic result_valid;
    logic [63:0] result;
    logic [1:0] result_size;
    logic illegal;
    logic flags_valid;
    logic [63:0] flags_register;
  } state_t;

  // reset image: no pulses, cleared result, flags with the fixed one bit
  localparam state_t STATE_RESET = '{
    result_valid: 1'b0,
    result: 64'h0,
    result_size: SIZE_8,
    illegal: 1'b0,
    flags_valid: 1'b0,
    flags_register: FLAGS_RESET
  };

  state_t state;
  state_t next_state;

  ////////////////////////////////////////////////////////////////
  // decode

  shift_kind_t kind;
  count_src_t src;
  logic is_grp2;
  logic is_flag_load;
  logic byte_form;
  logic ext_known;
  logic [7:0] raw_count;
  logic [5:0] amount;
  logic [1:0] eff_size;
  logic [63:0] shifted;
  logic [63:0] merged;

  // opcode byte: which group, which count source, byte or word form
  always_comb begin
    is_grp2 = 1'b1;
    is_flag_load = 1'b0;
    byte_form = 1'b0;
    src = src_one;
    case (opcode)
      // RULE7 byte forms
      OPC_GRP2_BYTE_ONE: begin
        byte_form = 1'b1;
        src = src_one;
      end
      OPC_GRP2_BYTE_CNT: begin
        byte_form = 1'b1;
        src = src_count;
      end
      OPC_GRP2_BYTE_IMM: begin
        byte_form = 1'b1;
        src = src_imm;
      end
      // RULE8 word forms
      OPC_GRP2_WORD_ONE: src = src_one;
      // RULE1 count register source
      OPC_GRP2_WORD_CNT: src = src_count;
      // RULE2 immediate source
      OPC_GRP2_WORD_IMM: src = src_imm;
      // RULE6 flag byte load carries no extension field
      OPC_FLAG_LOAD: begin
        is_grp2 = 1'b0;
        is_flag_load = 1'b1;
      end
      default: is_grp2 = 1'b0;
    endcase
  end

  // extension field: the operation within the group
  always_comb begin
    ext_known = 1'b1;
    case (modrm_ext)
      EXT_ROTATE_LEFT: kind = op_rotate_left;
      // RULE11 right rotate on ext 1
      EXT_ROTATE_RIGHT: kind = op_rotate_right;
      // RULE10 one encoding for both shifts
      EXT_SHIFT_LEFT: kind = op_shift_left;
      default: begin
        kind = op_none;
        ext_known = 1'b0;
      end
    endcase
  end

  // width and count
  always_comb begin
    // RULE9 width from size state
    // byte opcodes force 8 bits; size 8 on a word opcode is read as 16
    eff_size = byte_form ? SIZE_8 : (operand_size == SIZE_8 ? SIZE_16 : operand_size);
    case (src)
      src_count: raw_count = count_reg_low_byte;
      src_imm: raw_count = imm8;
      default: raw_count = 8'h01;
    endcase
    // count masked to 6 bits for 64-bit operands, 5 bits otherwise
    case (eff_size)
      SIZE_64: amount = raw_count[5:0];
      default: amount = {1'b0, raw_count[4:0]};
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // datapath

  // RULE3 RULE4 RULE5 rotate wraps
  shift_core #(
    .DATA_W(64)
  ) core (
    .operand(operand),
    .size(eff_size),
    .amount(amount),
    .kind(kind),
    .result(shifted)
  );

  // write-back image: narrow results keep the untouched upper operand bits,
  // 32-bit results clear them as a 32-bit register write does
  always_comb begin
    case (eff_size)
      SIZE_8: merged = {operand[63:8], shifted[7:0]};
      SIZE_16: merged = {operand[63:16], shifted[15:0]};
      SIZE_32: merged = {32'h0, shifted[31:0]};
      default: merged = shifted;
    endcase
  end

  always_comb begin
    next_state = state;
    // pulses last one enabled cycle
    next_state.result_valid = 1'b0;
    next_state.flags_valid = 1'b0;
    next_state.illegal = 1'b0;
    if (instr_valid) begin
      if (is_flag_load) begin
        // RULE6 low flag byte load; upper flag bits untouched
        next_state.flags_register[7:0] = (accumulator_high_byte & FLAG_LOAD_MASK) | FLAG_FIXED_ONE;
        next_state.flags_valid = 1'b1;
      end else if (is_grp2 && ext_known) begin
        next_state.result = merged;
        next_state.result_size = eff_size;
        next_state.result_valid = 1'b1;
      end else begin
        // other opcodes and group extensions belong to other units; result and flags keep their value
        next_state.illegal = 1'b1;
      end
    end
  end

  // clk_en low freezes the pulses too, so a pulse stretches while the enable is off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= STATE_RESET;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign result_valid = state.result_valid;
  assign result = state.result;
  assign result_size = state.result_size;
  assign illegal = state.illegal;
  assign flags_valid = state.flags_valid;
  assign flags_register = state.flags_register;

endmodule
`default_nettype wire

/* testbench/srfl_properties.sv */
// port assertions for the shift / rotate / flag-load unit
// assumes it is bound into the unit with 64-bit data
`timescale 1ns/100ps
`default_nettype none
module srfl_checker #(
  parameter int DATA_W = 64
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [2:0] modrm_ext,
  input wire logic [1:0] operand_size,
  input wire logic [DATA_W-1:0] operand,
  input wire logic [7:0] count_reg_low_byte,
  input wire logic [7:0] accumulator_high_byte,
  input wire logic result_valid,
  input wire logic [DATA_W-1:0] result,
  input wire logic illegal,
  input wire logic flags_valid,
  input wire logic [DATA_W-1:0] flags_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire tk = clk_en && instr_valid;
  wire q = tk && operand_size == 2'h3;
  wire [10:0] oe = {opcode, modrm_ext};
  function automatic logic [63:0] rl(input logic [63:0] v, input logic [5:0] n);
    rl = (v << n) | (v >> (7'h40 - n));
  endfunction
  chk_rotl_count:
    assert property (q && oe == {8'hD3, 3'h0} |=> result_valid && result == rl($past(operand),
      $past(count_reg_low_byte[5:0]))) else $error("rotate left by count");
  chk_rotr_wide:
    assert property (q && oe == {8'hD1, 3'h1} |=> result == rl($past(operand), 6'h3F))
      else $error("rotate right wide");
  chk_rotr_byte:
    assert property (tk && oe == {8'hD0, 3'h1} |=> result[7:0] == {$past(operand[0]),
      $past(operand[7:1])}) else $error("rotate right byte");
  chk_flag_copy:
    assert property (tk && opcode == 8'h9E |=> flags_valid && flags_register[7:0] ==
      ($past(accumulator_high_byte) & 8'hD5 | 8'h02)) else $error("flag load");
  chk_lshift_wide:
    assert property (q && oe == {8'hD1, 3'h4} |=> result == $past(operand) << 1) else $error("shift left wide");
  chk_lshift_byte:
    assert property (tk && oe == {8'hD0, 3'h4} |=> result == {$past(operand[63:8]), $past(operand[6:0]), 1'b0})
      else $error("shift left byte");
  chk_bad_ext:
    assert property (tk && modrm_ext == 3'h7 |=> illegal && !result_valid) else $error("illegal ext");
  chk_flags_hold:
    assert property (!flags_valid |-> $stable(flags_register)) else $error("flags moved");
endmodule
bind shift_rotate_flag_load_unit srfl_checker #(.DATA_W(DATA_W)) i_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .clk_en(clk_en),
  .instr_valid(instr_valid),
  .opcode(opcode),
  .modrm_ext(modrm_ext),
  .operand_size(operand_size),
  .operand(operand),
  .count_reg_low_byte(count_reg_low_byte),
  .accumulator_high_byte(accumulator_high_byte),
  .result_valid(result_valid),
  .result(result),
  .illegal(illegal),
  .flags_valid(flags_valid),
  .flags_register(flags_register)
);
`default_nettype wire

/* testbench/front_end_model.sv */
// fetch front end: hands one decoded instruction to the unit per call
// assumes the unit samples on the rising edge
`timescale 1ns/100ps
`default_nettype none
module front_end_model (
  input wire logic clk_sys,
  output logic instr_valid,
  output logic [7:0] opcode,
  output logic [2:0] modrm_ext,
  output logic [1:0] operand_size,
  output logic [63:0] operand,
  output logic [7:0] imm8,
  output logic [7:0] count_reg_low_byte,
  output logic [7:0] accumulator_high_byte
);
  initial begin
    {instr_valid, opcode, modrm_ext, operand_size, operand} = '0;
    {imm8, count_reg_low_byte, accumulator_high_byte} = '0;
  end
  // count, immediate and high byte share c; the opcode picks the source
  task automatic issue(input logic [7:0] o, input logic [2:0] e, input logic [1:0] s, input logic [63:0] v,
    input logic [7:0] c);
    @(negedge clk_sys);
    {instr_valid, opcode, modrm_ext, operand_size, operand} = {1'b1, o, e, s, v};
    {imm8, count_reg_low_byte, accumulator_high_byte} = {c, c, c};
    @(negedge clk_sys);
    // stale operand inverted so a late sample cannot match
    {instr_valid, operand} = {1'b0, ~v};
  endtask
endmodule
`default_nettype wire

/* testbench/test_shift_rotate_flag_load_unit.sv */
// self-checking bench for the shift / rotate / flag-load unit
// assumes front_end_model drives the instruction inputs
`timescale 1ns/100ps
`default_nettype none
module test_shift_rotate_flag_load_unit
  import shift_rotate_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic instr_valid, result_valid, illegal, flags_valid;
  logic [7:0] opcode, imm8, count_reg_low_byte, accumulator_high_byte;
  logic [2:0] modrm_ext;
  logic [1:0] operand_size, result_size;
  logic [63:0] operand, result, flags_register;
  int fails = 0;
  int n_checks = 0;
  localparam logic [63:0] V_SRC = 64'h8123456789ABCDEF;
  always #5 clk_sys = ~clk_sys;
  front_end_model i_fe (
    .clk_sys(clk_sys), .instr_valid(instr_valid), .opcode(opcode), .modrm_ext(modrm_ext),
    .operand_size(operand_size), .operand(operand), .imm8(imm8), .count_reg_low_byte(count_reg_low_byte),
    .accumulator_high_byte(accumulator_high_byte)
  );
  shift_rotate_flag_load_unit i_dut (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid), .opcode(opcode),
    .modrm_ext(modrm_ext), .operand_size(operand_size), .operand(operand), .imm8(imm8),
    .count_reg_low_byte(count_reg_low_byte), .accumulator_high_byte(accumulator_high_byte),
    .result_valid(result_valid), .result(result), .result_size(result_size), .illegal(illegal),
    .flags_valid(flags_valid), .flags_register(flags_register)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // k: 0 rotate left, 2 shift left; 8/16 keep upper bits, 32 zero-extends
  function automatic logic [63:0] ex(input int k, input int w, input logic [63:0] v, input int n);
    logic [63:0] m, r;
    m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
    r = v & m;
    for (int i = 0; i < n; i++) r = (k == 2) ? (r << 1) & m : ((r << 1) | (r >> (w - 1))) & m;
    ex = (w == 32) ? r : (v & ~m) | r;
  endfunction
  task automatic go(input logic [7:0] o, input logic [2:0] e, input logic [1:0] s, input logic [7:0] c,
    input logic [63:0] x);
    i_fe.issue(o, e, s, V_SRC, c);
    chk({63'h0, result_valid}, 64'h1);
    chk(result, x);
    chk({62'h0, result_size}, {62'h0, o[0] ? ((s == SIZE_8) ? SIZE_16 : s) : SIZE_8});
  endtask
  task automatic t_rotl;
    go(8'hD3, 3'h0, 2'h3, 8'h44, ex(0, 64, V_SRC, 4));
    go(8'hC1, 3'h0, 2'h2, 8'h08, ex(0, 32, V_SRC, 8));
    go(8'hC1, 3'h0, 2'h3, 8'h3F, ex(0, 64, V_SRC, 63));
  endtask
  task automatic t_rotr;
    go(8'hD0, 3'h1, 2'h3, 8'h00, ex(0, 8, V_SRC, 7));
    go(8'hD1, 3'h1, 2'h3, 8'h00, ex(0, 64, V_SRC, 63));
    go(8'hD3, 3'h1, 2'h2, 8'h05, ex(0, 32, V_SRC, 27));
    go(8'hC1, 3'h1, 2'h3, 8'h0C, ex(0, 64, V_SRC, 52));
  endtask
  task automatic t_shift;
    go(8'hD0, 3'h4, 2'h0, 8'h00, ex(2, 8, V_SRC, 1));
    go(8'hD2, 3'h4, 2'h0, 8'h03, ex(2, 8, V_SRC, 3));
    go(8'hC0, 3'h4, 2'h0, 8'h09, ex(2, 8, V_SRC, 9));
    go(8'hD1, 3'h4, 2'h1, 8'h00, ex(2, 16, V_SRC, 1));
    go(8'hD3, 3'h4, 2'h1, 8'h24, ex(2, 16, V_SRC, 4));
    go(8'hC1, 3'h4, 2'h1, 8'h0F, ex(2, 16, V_SRC, 15));
    go(8'hC1, 3'h4, 2'h2, 8'h1F, ex(2, 32, V_SRC, 31));
    go(8'hD1, 3'h4, 2'h3, 8'h00, ex(2, 64, V_SRC, 1));
    go(8'hC1, 3'h4, 2'h3, 8'h3F, ex(2, 64, V_SRC, 63));
  endtask
  task automatic t_flag_bad;
    i_fe.issue(8'h9E, 3'h0, 2'h0, V_SRC, 8'hFF);
    chk({63'h0, flags_valid}, 64'h1);
    chk(flags_register, 64'hD7);
    i_fe.issue(8'h9E, 3'h0, 2'h0, V_SRC, 8'h2A);
    chk(flags_register, 64'h02);
    i_fe.issue(8'hD3, 3'h7, 2'h3, V_SRC, 8'h01);
    chk({62'h0, illegal, result_valid}, 64'h2);
    chk(result, ex(2, 64, V_SRC, 63));
  endtask
  // enable low: the instruction is not taken and the last result stands
  task automatic t_hold;
    @(negedge clk_sys);
    clk_en = 1'b0;
    i_fe.issue(8'hD0, 3'h4, 2'h0, V_SRC, 8'h00);
    chk({62'h0, illegal, result_valid}, 64'h0);
    chk(result, ex(2, 64, V_SRC, 63));
    clk_en = 1'b1;
  endtask
  // mid-run reset after a flag load
  task automatic t_reset;
    i_fe.issue(8'h9E, 3'h0, 2'h0, V_SRC, 8'hFF);
    @(negedge clk_sys);
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    chk(flags_register, FLAGS_RESET);
    chk(result, 64'h0);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    chk(flags_register, FLAGS_RESET);
    t_rotl();
    t_rotr();
    t_shift();
    t_flag_bad();
    t_hold();
    t_reset();
    summarize();
  end
  initial begin
    #20000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
